// ### hw/ptir_defines.svh
// Offsets, field positions, reset values and widths of the pressure threshold block
`ifndef PTIR_DEFINES_SVH
`define PTIR_DEFINES_SVH

// ************************************************************
// Register addresses (7-bit)
// ************************************************************
`define PTIR_ADDR_W          7
`define PTIR_ADDR_IRQ_CFG    7'h0b
`define PTIR_ADDR_THS_LOW    7'h0c
`define PTIR_ADDR_THS_HIGH   7'h0d
`define PTIR_ADDR_REF_LOW    7'h15
`define PTIR_ADDR_REF_HIGH   7'h16
`define PTIR_ADDR_IRQ_SRC    7'h24
`define PTIR_ADDR_POUT_XL    7'h28
`define PTIR_ADDR_POUT_L     7'h29
`define PTIR_ADDR_POUT_H     7'h2a

// ************************************************************
// Configuration register fields
// ************************************************************
`define PTIR_CFG_HIGH_EN     0
`define PTIR_CFG_LOW_EN      1
`define PTIR_CFG_LATCH_EN    2
`define PTIR_CFG_THR_EN      3
`define PTIR_CFG_AZ_RESET    4
`define PTIR_CFG_AZ_EN       5
`define PTIR_CFG_AR_RESET    6
`define PTIR_CFG_AR_EN       7

// ************************************************************
// Interrupt source register fields
// ************************************************************
`define PTIR_SRC_HIGH        0
`define PTIR_SRC_LOW         1
`define PTIR_SRC_ACTIVE      2

// ************************************************************
// Reset values and widths
// ************************************************************
`define PTIR_CFG_RESET       8'h00
`define PTIR_THS_RESET       8'h00
`define PTIR_REF_RESET       16'h0000
`define PTIR_PRESS_W         24
`define PTIR_REF_W           16
`define PTIR_THS_W           15
`define PTIR_DIFF_W          17

`endif

// ### hw/ptir_pkg.sv
// Types shared by the pressure threshold block
package ptir_pkg;

  // Offset mode, one-hot
  typedef enum logic [2:0] {
    PTIR_MODE_NORMAL = 3'b001,
    PTIR_MODE_ZERO   = 3'b010,
    PTIR_MODE_REF    = 3'b100
  } ptir_mode_type;

endpackage

// ### hw/ptir_pressure_threshold.sv
// Pressure threshold interrupt and reference pressure logic
//
// Contract
// (R1) Registers are selected by a 7-bit address over the register port.
// (R2) Config bits 7..0: ar en, ar reset, az en, az reset, irq en, latch, low, high.
// (R3) Threshold interrupts only with irq enable and high or low event enable set.
// (R4) Latch enable holds requests in the source register at 24h; otherwise unlatched.
// (R5) Low event enable requests interrupt when differential falls below threshold.
// (R6) High event enable requests interrupt when differential rises above threshold.
// (R7) High enable governs positive events, low enable governs negative events.
// (R8) Threshold is 15-bit unsigned right-justified across low and high bytes.
// (R9) Host programs threshold as hPa times 16.
// (R10) Low byte holds bits 7..0, high byte bits 14..8; bit 7 unused; reset zero.
// (R11) Host uses differential interrupt only with auto-reference or auto-zero mode; the bench also enables it in normal mode via 1bh and 4fh writes.
// (R12) Auto-zero enable stores measured pressure as reference at 15h and 16h.
// (R13) Auto-zero mode: output and differential both carry measured minus reference.
// (R14) Auto-zero enable clears itself after the first conversion.
// (R15) Auto-zero reset returns to normal output and clears reference to zero.
// (R16) Auto-reference enable captures measured pressure as reference, interrupt use only.
// (R17) Auto-reference mode: differential is measured minus reference, output unadjusted.
// (R18) Auto-reference enable clears itself; auto-reference reset returns to normal.
// (R19) Negative event below negated threshold, positive event above threshold.
// (R20) Latched request stays until host reads source register, which clears it.
`timescale 1ns/1ps
`default_nettype none
`include "ptir_defines.svh"

module ptir_pressure_threshold
  import ptir_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [`PTIR_ADDR_W-1:0]   regAddr,
  input  wire logic                      regWrEn,
  input  wire logic [7:0]                regWrData,
  input  wire logic                      regRdEn,
  output var  logic [7:0]                regRdData,
  input  wire logic                      measValid,
  input  wire logic [`PTIR_PRESS_W-1:0]  measPressure,
  output var  logic [`PTIR_PRESS_W-1:0]  pressureOutput,
  output var  logic [`PTIR_DIFF_W-1:0]   differentialPressure,
  output var  logic                      irqOut
);

  // ************************************************************
  // Helpers
  // ************************************************************

  // Event decode: bit0 positive, bit1 negative, gated by enables
  function automatic logic [1:0] eventDecode(input logic [`PTIR_DIFF_W-1:0] diff,
                                             input logic [`PTIR_THS_W-1:0]  ths,
                                             input logic [7:0]              cfg);
    logic signed [`PTIR_DIFF_W:0] d;
    logic signed [`PTIR_DIFF_W:0] t;
    d = {diff[`PTIR_DIFF_W-1], diff};
    t = {3'b000, ths};
    eventDecode = 2'b00;
    if (cfg[`PTIR_CFG_THR_EN]) begin                                    // R3
      eventDecode[0] = cfg[`PTIR_CFG_HIGH_EN] && (d > t);              // R6 R7 R19
      eventDecode[1] = cfg[`PTIR_CFG_LOW_EN] && (d < -t);              // R5 R7 R19
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0]                 cfg_reg, cfg_next;
  logic [7:0]                 thsLow_reg, thsLow_next;
  logic [6:0]                 thsHigh_reg, thsHigh_next;
  logic [`PTIR_REF_W-1:0]     ref_reg, ref_next;
  ptir_mode_type              mode_reg, mode_next;
  logic [2:0]                 src_reg, src_next;
  logic [`PTIR_PRESS_W-1:0]   pout_reg, pout_next;
  logic [`PTIR_DIFF_W-1:0]    diff_reg, diff_next;
  logic [7:0]                 rd_reg, rd_next;
  logic                       irq_reg, irq_next;

  logic                       cfgWrite, srcRead;
  logic [`PTIR_THS_W-1:0]     threshold;
  logic [`PTIR_REF_W-1:0]     refUsed;
  logic [`PTIR_DIFF_W-1:0]    diffNow;
  logic [1:0]                 events;

  assign cfgWrite  = regWrEn && (regAddr == `PTIR_ADDR_IRQ_CFG);        // R1
  assign srcRead   = regRdEn && (regAddr == `PTIR_ADDR_IRQ_SRC);
  assign threshold = {thsHigh_reg, thsLow_reg};                         // R8

  // ************************************************************
  // Configuration, threshold, reference and mode
  // ************************************************************

  // Conversion effects first, then host writes; the write wins so a fresh enable is never lost
  always_comb begin
    cfg_next     = cfg_reg;
    thsLow_next  = thsLow_reg;
    thsHigh_next = thsHigh_reg;
    ref_next     = ref_reg;
    mode_next    = mode_reg;
    if (measValid && (cfg_reg[`PTIR_CFG_AZ_EN] || cfg_reg[`PTIR_CFG_AR_EN])) begin
      ref_next = measPressure[`PTIR_PRESS_W-1:8];                       // R12 R16
      mode_next = cfg_reg[`PTIR_CFG_AZ_EN] ? PTIR_MODE_ZERO : PTIR_MODE_REF;
      cfg_next[`PTIR_CFG_AZ_EN] = 1'b0;                                 // R14
      cfg_next[`PTIR_CFG_AR_EN] = 1'b0;                                 // R18
    end
    if (cfgWrite) begin
      cfg_next = regWrData;                                             // R2
      // Reset bits act as strobes and never read back as one
      cfg_next[`PTIR_CFG_AZ_RESET] = 1'b0;
      cfg_next[`PTIR_CFG_AR_RESET] = 1'b0;
      if (regWrData[`PTIR_CFG_AZ_RESET]) begin
        mode_next = PTIR_MODE_NORMAL;                                   // R15
        ref_next  = `PTIR_REF_RESET;                                    // R15
      end
      if (regWrData[`PTIR_CFG_AR_RESET] && (mode_reg == PTIR_MODE_REF)) begin
        mode_next = PTIR_MODE_NORMAL;                                   // R18
      end
    end
    if (regWrEn && (regAddr == `PTIR_ADDR_THS_LOW)) begin
      thsLow_next = regWrData;                                          // R10
    end
    if (regWrEn && (regAddr == `PTIR_ADDR_THS_HIGH)) begin
      thsHigh_next = regWrData[6:0];                                    // R10
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg     <= `PTIR_CFG_RESET;
      thsLow_reg  <= `PTIR_THS_RESET;
      thsHigh_reg <= 7'h00;
      ref_reg     <= `PTIR_REF_RESET;
      mode_reg    <= PTIR_MODE_NORMAL;
    end else begin
      cfg_reg     <= cfg_next;
      thsLow_reg  <= thsLow_next;
      thsHigh_reg <= thsHigh_next;
      ref_reg     <= ref_next;
      mode_reg    <= mode_next;
    end
  end

  // ************************************************************
  // Conversion datapath and interrupt source
  // ************************************************************

  // The captured reference applies to the very conversion that captured it
  always_comb begin
    refUsed = ref_next;
    diffNow = {1'b0, measPressure[`PTIR_PRESS_W-1:8]} - {1'b0, refUsed}; // R13 R17
    events  = eventDecode(diffNow, threshold, cfg_reg);
  end

  // Latched flags: a new event wins over a clearing read
  always_comb begin
    pout_next = pout_reg;
    diff_next = diff_reg;
    src_next  = src_reg;
    irq_next  = irq_reg;
    if (srcRead && cfg_reg[`PTIR_CFG_LATCH_EN]) begin
      src_next = 3'b000;                                                // R20
    end
    if (measValid) begin
      diff_next = diffNow;
      if (mode_next == PTIR_MODE_ZERO) begin
        pout_next = measPressure - {refUsed, 8'h00};                    // R13
      end else begin
        pout_next = measPressure;                                       // R17
      end
      if (cfg_reg[`PTIR_CFG_LATCH_EN]) begin
        src_next[1:0] = src_next[1:0] | events;                         // R4
      end else begin
        src_next[1:0] = events;                                         // R4
      end
    end
    src_next[`PTIR_SRC_ACTIVE] = |src_next[1:0];
    irq_next = src_next[`PTIR_SRC_ACTIVE];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pout_reg <= '0;
      diff_reg <= '0;
      src_reg  <= 3'b000;
      irq_reg  <= 1'b0;
    end else begin
      pout_reg <= pout_next;
      diff_reg <= diff_next;
      src_reg  <= src_next;
      irq_reg  <= irq_next;
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************

  // Read data is registered and held until the next read; unmapped reads give zero
  always_comb begin
    rd_next = rd_reg;
    if (regRdEn) begin
      unique case (regAddr)                                             // R1
        `PTIR_ADDR_IRQ_CFG:  rd_next = cfg_reg;
        `PTIR_ADDR_THS_LOW:  rd_next = thsLow_reg;
        `PTIR_ADDR_THS_HIGH: rd_next = {1'b0, thsHigh_reg};             // R10
        `PTIR_ADDR_REF_LOW:  rd_next = ref_reg[7:0];
        `PTIR_ADDR_REF_HIGH: rd_next = ref_reg[15:8];
        `PTIR_ADDR_IRQ_SRC:  rd_next = {5'h00, src_reg};
        `PTIR_ADDR_POUT_XL:  rd_next = pout_reg[7:0];
        `PTIR_ADDR_POUT_L:   rd_next = pout_reg[15:8];
        `PTIR_ADDR_POUT_H:   rd_next = pout_reg[23:16];
        default:             rd_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_reg <= 8'h00;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign regRdData            = rd_reg;
  assign pressureOutput       = pout_reg;
  assign differentialPressure = diff_reg;
  assign irqOut               = irq_reg;

  // ************************************************************
  // Assertions
  // ************************************************************

  no_event_gated_a: assert property (@(posedge clk) disable iff (rst) // R3
    (measValid && !cfg_reg[`PTIR_CFG_LATCH_EN] &&
     !(cfg_reg[`PTIR_CFG_THR_EN] && (cfg_reg[`PTIR_CFG_HIGH_EN] || cfg_reg[`PTIR_CFG_LOW_EN])))
    |=> (src_reg == 3'b000 && !irqOut))
    else $error("event flagged while threshold interrupts disabled");

  latch_holds_a: assert property (@(posedge clk) disable iff (rst) // R20
    (src_reg[`PTIR_SRC_ACTIVE] && cfg_reg[`PTIR_CFG_LATCH_EN] && !srcRead && !cfgWrite)
    |=> src_reg[`PTIR_SRC_ACTIVE])
    else $error("latched request dropped without a source read");

  high_event_a: assert property (@(posedge clk) disable iff (rst) // R6
    (measValid && cfg_reg[`PTIR_CFG_THR_EN] && cfg_reg[`PTIR_CFG_HIGH_EN] &&
     $signed({diffNow[`PTIR_DIFF_W-1], diffNow}) > $signed({3'b000, threshold}))
    |=> (src_reg[`PTIR_SRC_HIGH] && irqOut))
    else $error("high event not flagged");

  low_event_a: assert property (@(posedge clk) disable iff (rst) // R5
    (measValid && cfg_reg[`PTIR_CFG_THR_EN] && cfg_reg[`PTIR_CFG_LOW_EN] &&
     $signed({diffNow[`PTIR_DIFF_W-1], diffNow}) < -$signed({3'b000, threshold}))
    |=> (src_reg[`PTIR_SRC_LOW] && irqOut))
    else $error("low event not flagged");

  az_self_clear_a: assert property (@(posedge clk) disable iff (rst) // R14
    (measValid && cfg_reg[`PTIR_CFG_AZ_EN] && !cfgWrite)
    |=> (!cfg_reg[`PTIR_CFG_AZ_EN] && mode_reg == PTIR_MODE_ZERO &&
         ref_reg == $past(measPressure[`PTIR_PRESS_W-1:8])))
    else $error("auto-zero capture or self clear failed");

  az_reset_a: assert property (@(posedge clk) disable iff (rst) // R15
    (cfgWrite && regWrData[`PTIR_CFG_AZ_RESET])
    |=> (ref_reg == `PTIR_REF_RESET && mode_reg == PTIR_MODE_NORMAL))
    else $error("auto-zero reset did not clear reference");

  ar_output_a: assert property (@(posedge clk) disable iff (rst) // R17
    (measValid && mode_next == PTIR_MODE_REF)
    |=> (pressureOutput == $past(measPressure)))
    else $error("auto-reference changed the pressure output");

  az_output_a: assert property (@(posedge clk) disable iff (rst) // R13
    (measValid && mode_reg == PTIR_MODE_ZERO && !cfgWrite && !cfg_reg[`PTIR_CFG_AZ_EN] &&
     !cfg_reg[`PTIR_CFG_AR_EN])
    |=> (pressureOutput == $past(measPressure) - {$past(ref_reg), 8'h00}))
    else $error("auto-zero output not offset by reference");

  ar_capture_a: assert property (@(posedge clk) disable iff (rst) // R16
    (measValid && cfg_reg[`PTIR_CFG_AR_EN] && !cfg_reg[`PTIR_CFG_AZ_EN] && !cfgWrite)
    |=> (!cfg_reg[`PTIR_CFG_AR_EN] && mode_reg == PTIR_MODE_REF &&
         ref_reg == $past(measPressure[`PTIR_PRESS_W-1:8])))
    else $error("auto-reference capture or self clear failed");

  ar_reset_a: assert property (@(posedge clk) disable iff (rst) // R18
    (cfgWrite && regWrData[`PTIR_CFG_AR_RESET] && mode_reg == PTIR_MODE_REF && !measValid)
    |=> (mode_reg == PTIR_MODE_NORMAL))
    else $error("auto-reference reset did not return to normal mode");

  cfg_write_a: assert property (@(posedge clk) disable iff (rst) // R2
    cfgWrite
    |=> (cfg_reg[3:0] == $past(regWrData[3:0]) && !cfg_reg[`PTIR_CFG_AZ_RESET] &&
         !cfg_reg[`PTIR_CFG_AR_RESET]))
    else $error("configuration write not applied");

  ths_high_a: assert property (@(posedge clk) disable iff (rst) // R10
    (regWrEn && regAddr == `PTIR_ADDR_THS_HIGH)
    |=> (threshold[`PTIR_THS_W-1:8] == $past(regWrData[6:0])))
    else $error("threshold high byte not stored");

  // An unlatched source only follows conversions, so a read must leave it alone
  unlatched_read_a: assert property (@(posedge clk) disable iff (rst) // R4
    (srcRead && !cfg_reg[`PTIR_CFG_LATCH_EN] && !measValid)
    |=> $stable(src_reg))
    else $error("unlatched source cleared by a read");

  read_data_a: assert property (@(posedge clk) disable iff (rst) // R1
    (regRdEn && regAddr == `PTIR_ADDR_IRQ_CFG)
    |=> (regRdData == $past(cfg_reg)))
    else $error("configuration read data wrong");

endmodule

`default_nettype wire

// ### tb/ptir_host_model.sv
// Host controller model that drives the register port of the threshold block
`timescale 1ns/1ps
`default_nettype none
`include "ptir_defines.svh"

module ptir_host_model (
  input  wire logic                    clk,
  output var  logic [`PTIR_ADDR_W-1:0] regAddr,
  output var  logic                    regWrEn,
  output var  logic [7:0]              regWrData,
  output var  logic                    regRdEn,
  input  wire logic [7:0]              regRdData
);
  // Idle values at time zero; no strobe is raised before the bench asks for one
  initial begin
    regAddr   = 7'h7f;
    regWrEn   = 1'b0;
    regWrData = 8'h00;
    regRdEn   = 1'b0;
  end

  // ************************************************************
  // Register access
  // ************************************************************
  // One-cycle write pulse; a released bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge clk);
    regWrEn   = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask

  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d       = regRdData;
  endtask

  // Threshold is given in hPa; the register field counts sixteenths
  task automatic set_ths(input int hpa);
    logic [15:0] v;
    v = 16'(hpa * 16);
    wr(`PTIR_ADDR_THS_LOW, v[7:0]);
    wr(`PTIR_ADDR_THS_HIGH, {1'b0, v[14:8]});
  endtask
endmodule

`default_nettype wire

// ### tb/ptir_pressure_threshold_tb_top.sv
// Self-checking testbench of the pressure threshold block against a behavioural model
`timescale 1ns/1ps
`default_nettype none
`include "ptir_defines.svh"

module ptir_pressure_threshold_tb_top
  import ptir_pkg::*;
;
  logic        clk, rst, regWrEn, regRdEn, measValid, irqOut;
  logic [6:0]  regAddr;
  logic [7:0]  regWrData, regRdData;
  logic [23:0] measPressure, pressureOutput;
  logic [16:0] differentialPressure;
  int          mCfg, mThs, mRef, mSrc, mMode, mPout, error_cnt, tests_run;
  logic [6:0]  addrs [10] = '{7'h0b, 7'h0c, 7'h0d, 7'h15, 7'h16, 7'h24, 7'h28, 7'h29, 7'h2a, 7'h0f};

  ptir_pressure_threshold DUT (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .measValid(measValid),
    .measPressure(measPressure), .pressureOutput(pressureOutput),
    .differentialPressure(differentialPressure), .irqOut(irqOut));
  ptir_host_model HOST (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData));

  // ************************************************************
  // Checking and model
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Reset strobes always read back 0, so the model never stores them
  task automatic mwr(input logic [6:0] a, input logic [7:0] d);
    HOST.wr(a, d);
    if (a == `PTIR_ADDR_IRQ_CFG) begin
      mCfg = d & 8'haf;
      if (d[4]) begin
        mRef  = 0;
        mMode = 0;
      end
      if (d[6] && mMode == 2) mMode = 0;
    end
    if (a == `PTIR_ADDR_THS_LOW) mThs = (mThs & 32'h7f00) | d;
    if (a == `PTIR_ADDR_THS_HIGH) mThs = (mThs & 32'hff) | ((d & 8'h7f) << 8);
  endtask

  function automatic logic [7:0] expRd(input logic [6:0] a);
    case (a)
      `PTIR_ADDR_IRQ_CFG:  return mCfg[7:0];
      `PTIR_ADDR_THS_LOW:  return mThs[7:0];
      `PTIR_ADDR_THS_HIGH: return mThs[15:8];
      `PTIR_ADDR_REF_LOW:  return mRef[7:0];
      `PTIR_ADDR_REF_HIGH: return mRef[15:8];
      `PTIR_ADDR_IRQ_SRC:  return mSrc[7:0];
      `PTIR_ADDR_POUT_XL:  return mPout[7:0];
      `PTIR_ADDR_POUT_L:   return mPout[15:8];
      `PTIR_ADDR_POUT_H:   return mPout[23:16];
      default:             return 8'h00;
    endcase
  endfunction

  // A read of the source register empties it only while requests are latched
  task automatic mrd(input logic [6:0] a);
    logic [7:0] got;
    HOST.rd(a, got);
    chk($sformatf("register %h", a), {24'h0, expRd(a)}, {24'h0, got});
    if (a == `PTIR_ADDR_IRQ_SRC && mCfg[2]) mSrc = 0;
  endtask

  // One conversion; outputs are compared half a cycle after the pulse is taken
  task automatic conv(input logic [23:0] m);
    int d;
    int f;
    @(negedge clk);
    measValid    = 1'b1;
    measPressure = m;
    if (mCfg[5]) begin
      mRef    = m[23:8];
      mMode   = 1;
      mCfg[5] = 1'b0;
    end else if (mCfg[7]) begin
      mRef    = m[23:8];
      mMode   = 2;
      mCfg[7] = 1'b0;
    end
    d     = int'(m[23:8]) - mRef;
    mPout = (mMode == 1) ? ((m - (mRef << 8)) & 32'hffffff) : m;
    f     = (mCfg[3] && mCfg[0] && d > mThs) ? 1 : 0;
    f     = f | ((mCfg[3] && mCfg[1] && d < -mThs) ? 2 : 0);
    f     = f | ((f != 0) ? 4 : 0);
    mSrc  = mCfg[2] ? (mSrc | f) : f;
    @(negedge clk);
    measValid    = 1'b0;
    measPressure = ~m;
    chk("pressure output", mPout, {8'h0, pressureOutput});
    chk("differential", d & 32'h1ffff, {15'h0, differentialPressure});
    chk("irq", {31'h0, mSrc[2]}, {31'h0, irqOut});
  endtask

  // Steps on both sides of the threshold, where an off-by-one compare shows
  task automatic sweep();
    int offs[5];
    offs = '{-mThs - 1, -mThs, 0, mThs, mThs + 1};
    foreach (offs[k]) begin
      conv({16'(mRef + offs[k]), 8'($urandom)});
      mrd(`PTIR_ADDR_IRQ_SRC);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ************************************************************
  // Stimulus
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog; the whole sequence needs only a few hundred cycles
  initial begin
    #400000;
    error_cnt++;
    results();
  end

  initial begin
    logic [15:0] v;
    rst = 1'b1;
    measValid = 1'b0;
    measPressure = 24'h000000;
    {mCfg, mThs, mRef, mSrc, mMode, mPout, error_cnt, tests_run} = '0;
    void'($urandom(32'h0ac31cbf));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    foreach (addrs[i]) mrd(addrs[i]);
    repeat (4) begin
      v = 16'($urandom);
      mwr(`PTIR_ADDR_THS_LOW, v[7:0]);
      mwr(`PTIR_ADDR_THS_HIGH, {1'b0, v[14:8]});
      mrd(`PTIR_ADDR_THS_LOW);
      mrd(`PTIR_ADDR_THS_HIGH);
    end
    $display("reset and threshold test done");
    v = 16'($urandom_range(3, 0));
    HOST.set_ths(v);
    mThs = v * 16;
    mwr(`PTIR_ADDR_IRQ_CFG, 8'h2b);
    conv({16'($urandom_range(60000, 2000)), 8'($urandom)});
    foreach (addrs[i]) mrd(addrs[i]);
    sweep();
    mwr(`PTIR_ADDR_IRQ_CFG, 8'h1b);
    mrd(`PTIR_ADDR_REF_LOW);
    conv(24'($urandom));
    $display("auto-zero test done");
    mwr(`PTIR_ADDR_IRQ_CFG, 8'h8f);
    conv({16'($urandom_range(60000, 2000)), 8'($urandom)});
    foreach (addrs[i]) mrd(addrs[i]);
    sweep();
    for (int i = 0; i < 16; i++) begin
      mwr(`PTIR_ADDR_IRQ_CFG, 8'(i));
      conv({16'(mRef + mThs + 1), 8'($urandom)});
      conv({16'(mRef), 8'($urandom)});
      conv({16'(mRef - mThs - 1), 8'($urandom)});
      mrd(`PTIR_ADDR_IRQ_SRC);
    end
    mwr(`PTIR_ADDR_IRQ_CFG, 8'h4f);
    conv(24'($urandom));
    $display("auto-reference and gating test done");
    results();
  end
endmodule

`default_nettype wire
